// file: logic/cpuamd_pkg.sv
// Constants, types and opcode classing for the addressing-mode decoder
package cpuamd_pkg;

	// Prebyte codes
	localparam logic [7:0] CPUAMD_PRE_NONE = 8'h00;
	localparam logic [7:0] CPUAMD_PRE_Y = 8'h90;
	localparam logic [7:0] CPUAMD_PRE_IY = 8'h91;
	localparam logic [7:0] CPUAMD_PRE_IND = 8'h92;

	// Opcode high nibble: addressing family of the base opcode; then jump/call low nibbles and single opcodes
	localparam logic [3:0] CPUAMD_NIB_BITREL = 4'h0;
	localparam logic [3:0] CPUAMD_NIB_BIT = 4'h1;
	localparam logic [3:0] CPUAMD_NIB_JR = 4'h2;
	localparam logic [3:0] CPUAMD_NIB_RMW_DIR = 4'h3;
	localparam logic [3:0] CPUAMD_NIB_RMW_A = 4'h4;
	localparam logic [3:0] CPUAMD_NIB_RMW_X = 4'h5;
	localparam logic [3:0] CPUAMD_NIB_RMW_IDXS = 4'h6;
	localparam logic [3:0] CPUAMD_NIB_RMW_IDX0 = 4'h7;
	localparam logic [3:0] CPUAMD_NIB_MISC8 = 4'h8;
	localparam logic [3:0] CPUAMD_NIB_MISC9 = 4'h9;
	localparam logic [3:0] CPUAMD_NIB_IMM = 4'ha;
	localparam logic [3:0] CPUAMD_NIB_DIRS = 4'hb;
	localparam logic [3:0] CPUAMD_NIB_DIRL = 4'hc;
	localparam logic [3:0] CPUAMD_NIB_IDXL = 4'hd;
	localparam logic [3:0] CPUAMD_NIB_IDXS = 4'he;
	localparam logic [3:0] CPUAMD_NIB_IDX0 = 4'hf;
	localparam logic [3:0] CPUAMD_LOW_JUMP = 4'hc;
	localparam logic [3:0] CPUAMD_LOW_CALL = 4'hd;
	localparam logic [7:0] CPUAMD_OP_RELCALL = 8'had;
	localparam logic [7:0] CPUAMD_OP_MUL = 8'h42;

	// Reset values, page zero and range limits
	localparam logic [15:0] CPUAMD_RST_ADDR = 16'h0000;
	localparam logic [7:0] CPUAMD_RST_BYTE = 8'h00;
	localparam logic [7:0] CPUAMD_PAGE0 = 8'h00;
	localparam logic [15:0] CPUAMD_SHORT_IDX_MAX = 16'h01fe;
	localparam logic [2:0] CPUAMD_LEN_MIN = 3'h1;
	localparam logic [2:0] CPUAMD_LEN_MAX = 3'h4;

	typedef enum logic [4:0] {
		M_INH, M_IMM, M_DIR_S, M_DIR_L, M_IDX0, M_IDX_S, M_IDX_L, M_IND_S, M_IND_L,
		M_IIX_S, M_IIX_L, M_REL_D, M_REL_I, M_BIT_D, M_BIT_I, M_BITREL_D, M_BITREL_I
	} cpuamd_mode_t;

	typedef enum logic [3:0] {
		G_LOAD, G_STACK, G_INCDEC, G_CMP, G_LOGIC, G_BIT, G_BITBR, G_ARITH,
		G_SHIFT, G_JUMP, G_CONDBR, G_INT, G_FLAG, G_NONE
	} cpuamd_group_t;

	typedef enum logic [3:0] {
		S_IDLE, S_OP, S_B1, S_B2, S_PHI, S_PLO, S_CALC, S_OPND, S_FIN
	} cpuamd_state_t;

	// Functional group of a base opcode; G_NONE marks an unused code
	function automatic cpuamd_group_t cpuamd_group_of(input logic [7:0] op);
		cpuamd_group_t g;
		g = G_NONE;
		case (op[7:4])
			CPUAMD_NIB_BITREL: g = G_BITBR;
			CPUAMD_NIB_BIT: g = G_BIT;
			CPUAMD_NIB_JR: g = (op[3:1] == 3'h0) ? G_JUMP : G_CONDBR;
			CPUAMD_NIB_MISC8: begin
				case (op[3:0])
					4'h0, 4'h3, 4'he, 4'hf: g = G_INT;
					4'h1: g = G_JUMP;
					4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha: g = G_STACK;
					default: g = G_NONE;
				endcase
			end
			CPUAMD_NIB_MISC9: begin
				case (op[3:0])
					4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'he, 4'hf: g = G_LOAD;
					4'h8, 4'h9, 4'ha, 4'hb: g = G_FLAG;
					4'hc: g = G_STACK;
					4'hd: g = G_JUMP;
					default: g = G_NONE;
				endcase
			end
			CPUAMD_NIB_RMW_DIR, CPUAMD_NIB_RMW_A, CPUAMD_NIB_RMW_X,
			CPUAMD_NIB_RMW_IDXS, CPUAMD_NIB_RMW_IDX0: begin
				case (op[3:0])
					4'h0, 4'h3: g = G_LOGIC;
					4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'he: g = G_SHIFT;
					4'ha, 4'hc: g = G_INCDEC;
					4'hd: g = G_CMP;
					4'hf: g = G_LOAD;
					4'h2: g = (op == CPUAMD_OP_MUL) ? G_ARITH : G_NONE;
					default: g = G_NONE;
				endcase
			end
			default: begin
				case (op[3:0])
					4'h0, 4'h2, 4'h9, 4'hb: g = G_ARITH;
					4'h1, 4'h3, 4'h5: g = G_CMP;
					4'h4, 4'h8, 4'ha: g = G_LOGIC;
					4'hc, 4'hd: g = G_JUMP;
					default: g = G_LOAD;
				endcase
				// Stores and absolute jump have no immediate form
				if (op[7:4] == CPUAMD_NIB_IMM && (op[3:0] == 4'h7 || op[3:0] == 4'hf ||
					op[3:0] == CPUAMD_LOW_JUMP)) begin
					g = G_NONE;
				end
			end
		endcase
		return g;
	endfunction

endpackage

// file: logic/cpuamd_decoder.sv
// Instruction fetch, addressing-mode decode and effective-address generation
module cpuamd_decoder
	import cpuamd_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic start,
	input wire logic [15:0] start_pc,
	input wire logic [7:0] idx_x,
	input wire logic [7:0] idx_y,
	output logic pm_rd,
	output logic [15:0] pm_addr,
	input wire logic [7:0] pm_rdata,
	output logic dm_rd,
	output logic [15:0] dm_addr,
	input wire logic [7:0] dm_rdata,
	output logic busy,
	output logic done,
	output logic [7:0] prefix,
	output logic [7:0] opcode,
	output cpuamd_mode_t mode,
	output cpuamd_group_t group,
	output logic use_y,
	output logic long_ok,
	output logic short_only,
	output logic illegal,
	output logic [2:0] instr_len,
	output logic [15:0] ea,
	output logic [7:0] operand,
	output logic operand_valid,
	output logic [7:0] rel_offset,
	output logic [15:0] branch_target,
	output logic [15:0] next_pc
);

	cpuamd_state_t state_r;
	logic wait_r;
	logic [15:0] pc_r;
	logic [7:0] pre_r;
	logic [7:0] op_r;
	logic [7:0] b1_r;
	logic [7:0] b2_r;
	logic [15:0] ptr_r;
	logic [7:0] idx_r;
	logic [2:0] len_r;
	logic [15:0] dm_addr_r;
	cpuamd_mode_t mode_r;
	cpuamd_group_t group_r;
	logic use_y_r;
	logic long_ok_r;
	logic short_only_r;
	logic bad_r;
	logic [15:0] ea_r;
	logic [7:0] operand_r;
	logic opnd_ok_r;
	logic [7:0] rel_r;
	logic [15:0] target_r;
	cpuamd_mode_t dec_mode;
	cpuamd_group_t dec_group;
	logic dec_bad;
	logic is_pre;
	logic [1:0] nbytes;
	logic ptr_mode;
	logic ptr_long;
	logic needs_opnd;
	logic [15:0] ea_nxt;
	logic [7:0] rel_nxt;
	logic [15:0] idx16;

	// Mode after the prebyte has been applied to the base opcode
	function automatic cpuamd_mode_t mode_of(input logic [7:0] pre, input logic [7:0] op);
		logic ind;
		cpuamd_mode_t m;
		ind = (pre == CPUAMD_PRE_IND) || (pre == CPUAMD_PRE_IY);
		m = M_INH;
		case (op[7:4])
			CPUAMD_NIB_BITREL: m = ind ? M_BITREL_I : M_BITREL_D;
			CPUAMD_NIB_BIT: m = ind ? M_BIT_I : M_BIT_D;
			CPUAMD_NIB_JR: m = ind ? M_REL_I : M_REL_D;
			CPUAMD_NIB_RMW_DIR, CPUAMD_NIB_DIRS: m = ind ? M_IND_S : M_DIR_S;
			CPUAMD_NIB_DIRL: m = ind ? M_IND_L : M_DIR_L;
			CPUAMD_NIB_IDXL: m = ind ? M_IIX_L : M_IDX_L;
			CPUAMD_NIB_RMW_IDXS, CPUAMD_NIB_IDXS: m = ind ? M_IIX_S : M_IDX_S;
			CPUAMD_NIB_RMW_IDX0, CPUAMD_NIB_IDX0: m = M_IDX0;
			CPUAMD_NIB_IMM: m = M_IMM;
			default: m = M_INH;
		endcase
		if (op == CPUAMD_OP_RELCALL) begin
			m = ind ? M_REL_I : M_REL_D;
		end
		return m;
	endfunction

	// Prebyte placed before an opcode it cannot modify
	function automatic logic pre_bad(input logic [7:0] pre, input logic [7:0] op);
		logic [3:0] hi;
		logic b;
		hi = op[7:4];
		b = 1'b0;
		if (pre == CPUAMD_PRE_Y) begin
			b = (hi == CPUAMD_NIB_BITREL) || (hi == CPUAMD_NIB_BIT) ||
				(hi == CPUAMD_NIB_JR) || (op == CPUAMD_OP_RELCALL);
		end else if (pre == CPUAMD_PRE_IND) begin
			b = (op != CPUAMD_OP_RELCALL) && ((hi == CPUAMD_NIB_RMW_A) ||
				(hi == CPUAMD_NIB_RMW_X) || (hi == CPUAMD_NIB_RMW_IDX0) ||
				(hi == CPUAMD_NIB_MISC8) || (hi == CPUAMD_NIB_MISC9) ||
				(hi == CPUAMD_NIB_IMM) || (hi == CPUAMD_NIB_IDX0));
		end else if (pre == CPUAMD_PRE_IY) begin
			b = !((hi == CPUAMD_NIB_RMW_IDXS) || (hi == CPUAMD_NIB_IDXL) ||
				(hi == CPUAMD_NIB_IDXS));
		end
		return b;
	endfunction

	// Opcode-time decode of the byte arriving from program memory
	always_comb begin
		is_pre = (pm_rdata == CPUAMD_PRE_Y) || (pm_rdata == CPUAMD_PRE_IY) ||
			(pm_rdata == CPUAMD_PRE_IND);
		dec_mode = mode_of(pre_r, pm_rdata);
		dec_group = cpuamd_group_of(pm_rdata);
		dec_bad = pre_bad(pre_r, pm_rdata) || (dec_group == G_NONE);
	end

	// Address bytes after the opcode, and pointer needs, per mode
	always_comb begin
		nbytes = 2'h1;
		ptr_mode = 1'b0;
		ptr_long = 1'b0;
		unique case (mode_r)
			M_INH, M_IDX0: nbytes = 2'h0;
			M_DIR_L, M_IDX_L, M_BITREL_D: nbytes = 2'h2;
			M_BITREL_I: begin
				nbytes = 2'h2;
				ptr_mode = 1'b1;
			end
			M_IND_S, M_IIX_S, M_REL_I, M_BIT_I: ptr_mode = 1'b1;
			M_IND_L, M_IIX_L: begin
				ptr_mode = 1'b1;
				ptr_long = 1'b1;
			end
			M_IMM, M_DIR_S, M_IDX_S, M_REL_D, M_BIT_D: nbytes = 2'h1;
		endcase
		needs_opnd = !(mode_r inside {M_INH, M_IMM, M_REL_D, M_REL_I}) &&
			(group_r != G_JUMP);
	end

	// Effective address and relative offset from the gathered bytes
	always_comb begin
		idx16 = {CPUAMD_PAGE0, idx_r};
		ea_nxt = CPUAMD_RST_ADDR;
		rel_nxt = CPUAMD_RST_BYTE;
		unique case (mode_r)
			M_DIR_S, M_BIT_D: ea_nxt = {CPUAMD_PAGE0, b1_r};
			M_BITREL_D: begin
				ea_nxt = {CPUAMD_PAGE0, b1_r};
				rel_nxt = b2_r;
			end
			M_DIR_L: ea_nxt = {b1_r, b2_r};
			M_IDX0: ea_nxt = idx16;
			M_IDX_S: ea_nxt = {CPUAMD_PAGE0, b1_r} + idx16;
			M_IDX_L: ea_nxt = {b1_r, b2_r} + idx16;
			M_IND_S, M_BIT_I: ea_nxt = {CPUAMD_PAGE0, ptr_r[7:0]};
			M_BITREL_I: begin
				ea_nxt = {CPUAMD_PAGE0, ptr_r[7:0]};
				rel_nxt = b2_r;
			end
			M_IND_L: ea_nxt = ptr_r;
			M_IIX_S: ea_nxt = {CPUAMD_PAGE0, ptr_r[7:0]} + idx16;
			M_IIX_L: ea_nxt = ptr_r + idx16;
			M_REL_D: rel_nxt = b1_r;
			M_REL_I: rel_nxt = ptr_r[7:0];
			M_INH, M_IMM: ea_nxt = CPUAMD_RST_ADDR;
		endcase
	end

	// Fetch sequencer; each memory byte takes a request cycle and a capture cycle
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_r <= S_IDLE;
			wait_r <= 1'b0;
			pc_r <= CPUAMD_RST_ADDR;
			pre_r <= CPUAMD_PRE_NONE;
			op_r <= CPUAMD_RST_BYTE;
			b1_r <= CPUAMD_RST_BYTE;
			b2_r <= CPUAMD_RST_BYTE;
			ptr_r <= CPUAMD_RST_ADDR;
			len_r <= 3'h0;
			dm_addr_r <= CPUAMD_RST_ADDR;
		end else if (ce) begin
			unique case (state_r)
				S_IDLE: begin
					if (start) begin
						pc_r <= start_pc;
						pre_r <= CPUAMD_PRE_NONE;
						len_r <= 3'h0;
						wait_r <= 1'b0;
						state_r <= S_OP;
					end
				end
				S_OP: begin
					wait_r <= !wait_r;
					if (wait_r) begin
						pc_r <= pc_r + 16'h0001;
						len_r <= len_r + 3'h1;
						if (is_pre && pre_r == CPUAMD_PRE_NONE) begin
							pre_r <= pm_rdata;
						end else begin
							op_r <= pm_rdata;
							// Bad codes stop before any operand fetch
							if (dec_bad) begin
								state_r <= S_FIN;
							end else if (dec_mode inside {M_INH, M_IDX0}) begin
								state_r <= S_CALC;
							end else begin
								state_r <= S_B1;
							end
						end
					end
				end
				S_B1: begin
					wait_r <= !wait_r;
					if (wait_r) begin
						pc_r <= pc_r + 16'h0001;
						len_r <= len_r + 3'h1;
						b1_r <= pm_rdata;
						dm_addr_r <= {CPUAMD_PAGE0, pm_rdata};
						if (nbytes == 2'h2) begin
							state_r <= S_B2;
						end else if (ptr_long) begin
							state_r <= S_PHI;
						end else if (ptr_mode) begin
							state_r <= S_PLO;
						end else begin
							state_r <= S_CALC;
						end
					end
				end
				S_B2: begin
					wait_r <= !wait_r;
					if (wait_r) begin
						pc_r <= pc_r + 16'h0001;
						len_r <= len_r + 3'h1;
						b2_r <= pm_rdata;
						state_r <= ptr_mode ? S_PLO : S_CALC;
					end
				end
				S_PHI: begin
					wait_r <= !wait_r;
					if (wait_r) begin
						ptr_r[15:8] <= dm_rdata;
						dm_addr_r <= dm_addr_r + 16'h0001;
						state_r <= S_PLO;
					end
				end
				S_PLO: begin
					wait_r <= !wait_r;
					if (wait_r) begin
						ptr_r[7:0] <= dm_rdata;
						state_r <= S_CALC;
					end
				end
				S_CALC: begin
					dm_addr_r <= ea_nxt;
					wait_r <= 1'b0;
					state_r <= needs_opnd ? S_OPND : S_FIN;
				end
				S_OPND: begin
					wait_r <= !wait_r;
					if (wait_r) begin
						state_r <= S_FIN;
					end
				end
				S_FIN: state_r <= S_IDLE;
			endcase
		end
	end

	// Instruction attributes, caught with the opcode
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mode_r <= M_INH;
			group_r <= G_NONE;
			use_y_r <= 1'b0;
			long_ok_r <= 1'b0;
			short_only_r <= 1'b0;
			bad_r <= 1'b0;
			idx_r <= CPUAMD_RST_BYTE;
		end else if (ce && state_r == S_OP && wait_r && !(is_pre && pre_r == CPUAMD_PRE_NONE)) begin
			mode_r <= dec_mode;
			group_r <= dec_group;
			bad_r <= dec_bad;
			use_y_r <= (pre_r == CPUAMD_PRE_Y) || (pre_r == CPUAMD_PRE_IY);
			// Index is sampled once so the sum cannot tear mid-instruction
			idx_r <= ((pre_r == CPUAMD_PRE_Y) || (pre_r == CPUAMD_PRE_IY)) ? idx_y : idx_x;
			long_ok_r <= (pm_rdata[7:4] >= CPUAMD_NIB_IMM) &&
				(dec_group inside {G_LOAD, G_CMP, G_LOGIC, G_ARITH});
			short_only_r <= (pm_rdata[7:4] inside {CPUAMD_NIB_BITREL, CPUAMD_NIB_BIT,
				CPUAMD_NIB_RMW_DIR, CPUAMD_NIB_RMW_IDXS, CPUAMD_NIB_RMW_IDX0}) ||
				(dec_group == G_JUMP && pm_rdata[7:4] >= CPUAMD_NIB_DIRS);
		end
	end

	// Address, operand and branch results
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ea_r <= CPUAMD_RST_ADDR;
			operand_r <= CPUAMD_RST_BYTE;
			opnd_ok_r <= 1'b0;
			rel_r <= CPUAMD_RST_BYTE;
			target_r <= CPUAMD_RST_ADDR;
		end else if (ce) begin
			if (state_r == S_IDLE && start) begin
				opnd_ok_r <= 1'b0;
			end
			if (state_r == S_CALC) begin
				ea_r <= ea_nxt;
				rel_r <= rel_nxt;
				// Program counter already points past the instruction here
				target_r <= pc_r + {{8{rel_nxt[7]}}, rel_nxt};
				if (mode_r == M_IMM) begin
					operand_r <= b1_r;
					opnd_ok_r <= 1'b1;
				end
			end
			if (state_r == S_OPND && wait_r) begin
				operand_r <= dm_rdata;
				opnd_ok_r <= 1'b1;
			end
		end
	end

	// Memory strobes are plain state decodes
	assign pm_rd = (state_r inside {S_OP, S_B1, S_B2}) && !wait_r;
	assign pm_addr = pc_r;
	assign dm_rd = (state_r inside {S_PHI, S_PLO, S_OPND}) && !wait_r;
	assign dm_addr = dm_addr_r;
	assign busy = (state_r != S_IDLE);
	assign done = (state_r == S_FIN);
	assign prefix = pre_r;
	assign opcode = op_r;
	assign mode = mode_r;
	assign group = group_r;
	assign use_y = use_y_r;
	assign long_ok = long_ok_r;
	assign short_only = short_only_r;
	assign illegal = bad_r;
	assign instr_len = len_r;
	assign ea = ea_r;
	assign operand = operand_r;
	assign operand_valid = opnd_ok_r;
	assign rel_offset = rel_r;
	assign branch_target = target_r;
	assign next_pc = pc_r;

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	AST_IDX_SUM: assert property (done && !bad_r && mode_r == M_IDX_S |->
		ea_r == {CPUAMD_PAGE0, b1_r} + {CPUAMD_PAGE0, idx_r})
		else $error("short indexed address is not offset plus index");
	AST_IDX0_PAGE: assert property (done && !bad_r && mode_r == M_IDX0 |->
		ea_r[15:8] == CPUAMD_PAGE0 && len_r == (pre_r == CPUAMD_PRE_NONE ? 3'h1 : 3'h2))
		else $error("zero-offset indexed left page zero or took extra bytes");
	AST_IDXS_RANGE: assert property (done && mode_r == M_IDX_S |->
		ea_r <= CPUAMD_SHORT_IDX_MAX)
		else $error("short indexed address beyond 1fe");
	AST_IND_L_PTR: assert property (done && !bad_r && mode_r == M_IND_L |->
		ea_r == ptr_r)
		else $error("long indirect address differs from fetched pointer");
	AST_IND_S_PAGE: assert property (done && mode_r == M_IND_S |->
		ea_r[15:8] == CPUAMD_PAGE0)
		else $error("short indirect address left page zero");
	AST_REL_TARGET: assert property (done && mode_r inside {M_REL_D, M_REL_I} |->
		target_r == pc_r + {{8{rel_r[7]}}, rel_r})
		else $error("relative target wrong");
	AST_LEN: assert property (done |->
		len_r >= CPUAMD_LEN_MIN && len_r <= CPUAMD_LEN_MAX)
		else $error("instruction length out of range");
	AST_PRE_IY: assert property (done && !bad_r && pre_r == CPUAMD_PRE_IY |->
		use_y_r && mode_r inside {M_IIX_S, M_IIX_L})
		else $error("second-index indirect prefix not applied");
	AST_PTR_THEN_OPND: assert property ($rose(state_r == S_CALC) && ptr_mode &&
		needs_opnd && ce |=> state_r == S_OPND && dm_addr_r == ea_r)
		else $error("operand not fetched at pointer-derived address");
	AST_OPND_DONE: assert property (ce && state_r == S_OPND && wait_r |=>
		done && operand_valid)
		else $error("operand fetch did not complete instruction");

endmodule

// file: verif/cpuamd_mem_model.sv
// Program and data memory model answering the decoder's byte reads
module cpuamd_mem_model (
	input wire logic mclk,
	input wire logic ce,
	input wire logic pm_rd,
	input wire logic [15:0] pm_addr,
	output logic [7:0] pm_rdata,
	input wire logic dm_rd,
	input wire logic [15:0] dm_addr,
	output logic [7:0] dm_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	// Contents are loaded by the bench before the first request
	logic [7:0] pmem [0:65535];
	logic [7:0] dmem [0:65535];

	initial begin
		pm_rdata = 8'h00;
		dm_rdata = 8'h00;
	end

	// One-cycle synchronous read; frozen while ce is low
	// Outside the answer cycle the bytes flip, so a late capture shows up
	always @(posedge mclk) begin
		if (ce === 1'b1) begin
			pm_rdata <= pm_rd ? pmem[pm_addr] : ~pm_rdata;
			dm_rdata <= dm_rd ? dmem[dm_addr] : ~dm_rdata;
		end
	end
endmodule

// file: verif/cpu_addressing_mode_decoder_test.sv
// Self-checking bench for the addressing-mode decoder
module cpu_addressing_mode_decoder_test;
	timeunit 1ns;
	timeprecision 1ps;
	import cpuamd_pkg::*;

	typedef struct {
		cpuamd_mode_t mode;
		cpuamd_group_t grp;
		logic [2:0] len;
		logic [15:0] ea, npc, tgt;
		logic [7:0] opd, pre, op, rel;
		logic opv, uy, lo, so, ill;
	} cpuamd_exp_t;

	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic ce_rand = 1'b0;
	logic start = 1'b0;
	logic [15:0] start_pc = 16'h0000;
	logic [7:0] idx_x = 8'h00;
	logic [7:0] idx_y = 8'h00;
	logic pm_rd, dm_rd, busy, done, use_y, long_ok, short_only, illegal, operand_valid;
	logic [15:0] pm_addr, dm_addr, ea, branch_target, next_pc;
	logic [7:0] pm_rdata, dm_rdata, prefix, opcode, operand, rel_offset;
	logic [2:0] instr_len;
	cpuamd_mode_t mode;
	cpuamd_group_t group;
	int seed = 93;
	int miscompares = 0;
	int num_checks = 0;
	cpuamd_exp_t expq[$];
	logic [15:0] pc;
	logic [7:0] x, y, b1, b2;

	cpuamd_decoder DUT (.mclk(mclk), .rst(rst), .ce(ce), .start(start), .start_pc(start_pc),
		.idx_x(idx_x), .idx_y(idx_y), .pm_rd(pm_rd), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
		.dm_rd(dm_rd), .dm_addr(dm_addr), .dm_rdata(dm_rdata), .busy(busy), .done(done),
		.prefix(prefix), .opcode(opcode), .mode(mode), .group(group), .use_y(use_y),
		.long_ok(long_ok), .short_only(short_only), .illegal(illegal), .instr_len(instr_len),
		.ea(ea), .operand(operand), .operand_valid(operand_valid), .rel_offset(rel_offset),
		.branch_target(branch_target), .next_pc(next_pc));

	cpuamd_mem_model mem (.mclk(mclk), .ce(ce), .pm_rd(pm_rd), .pm_addr(pm_addr),
		.pm_rdata(pm_rdata), .dm_rd(dm_rd), .dm_addr(dm_addr), .dm_rdata(dm_rdata));

	always #12.5 mclk = ~mclk;

	// Clock enable: steady, or randomly dropped about one cycle in four to stretch transfers
	always @(posedge mclk) begin
		#1;
		ce <= ce_rand ? (($random(seed) & 3) != 0) : 1'b1;
	end

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Expected result; flags f = {use_y, long_ok, short_only, illegal}
	function automatic cpuamd_exp_t mk(input cpuamd_mode_t m, input cpuamd_group_t g,
		input logic [2:0] n, input logic [15:0] a, input logic [7:0] r, input logic [3:0] f);
		cpuamd_exp_t e;
		e.mode = m;
		e.grp = g;
		e.len = n;
		e.ea = a;
		e.npc = pc + 16'(n);
		e.tgt = e.npc + {{8{r[7]}}, r};
		e.opd = mem.dmem[a];
		e.rel = r;
		e.pre = 8'h00;
		e.op = 8'h00;
		e.opv = !(m inside {M_INH, M_REL_D, M_REL_I});
		{e.uy, e.lo, e.so, e.ill} = f;
		return e;
	endfunction

	// Word pointer: high byte first, low byte at the next address
	function automatic logic [15:0] ptrw(input logic [7:0] p);
		return {mem.dmem[{8'h00, p}], mem.dmem[{8'h00, p} + 16'h0001]};
	endfunction

	function automatic logic [15:0] ptrb(input logic [7:0] p);
		return {8'h00, mem.dmem[{8'h00, p}]};
	endfunction

	task automatic rnd();
		pc = 16'($random(seed)) & 16'h7fff;
		x = 8'($random(seed));
		y = 8'($random(seed));
		b1 = 8'($random(seed));
		b2 = 8'($random(seed));
	endtask

	// Place the bytes, note the expectation, start and wait for idle
	task automatic issue(input logic [31:0] code, input cpuamd_exp_t e);
		for (int i = 0; i < 4; i++) mem.pmem[pc + 16'(i)] = code[31 - 8 * i -: 8];
		// A leading prebyte is kept apart from the opcode that follows it
		if (code[31:24] inside {8'h90, 8'h91, 8'h92}) begin
			e.pre = code[31:24];
			e.op = code[23:16];
		end else begin
			e.pre = 8'h00;
			e.op = code[31:24];
		end
		expq.push_back(e);
		@(posedge mclk);
		#1;
		start_pc = pc;
		idx_x = x;
		idx_y = y;
		start = 1'b1;
		do @(posedge mclk); while (ce !== 1'b1);
		#1;
		start = 1'b0;
		for (int k = 0; k < 300; k++) begin
			@(posedge mclk);
			#1;
			if (busy === 1'b0) break;
		end
	endtask

	// Result watcher on the falling edge, where done and ce are settled
	always @(negedge mclk) begin
		cpuamd_exp_t e;
		if (done === 1'b1 && ce === 1'b1) begin
			if (expq.size() == 0) begin
				chk("spurious done", 16'h0001, 16'h0000);
			end else begin
				e = expq.pop_front();
				chk("illegal", illegal, e.ill);
				chk("instr_len", instr_len, e.len);
				chk("prefix", 16'(prefix), 16'(e.pre));
				chk("opcode", 16'(opcode), 16'(e.op));
				if (!e.ill) begin
					chk("mode", mode, e.mode);
					chk("group", group, e.grp);
					chk("use_y", use_y, e.uy);
					chk("long_ok", long_ok, e.lo);
					chk("short_only", short_only, e.so);
					chk("ea", ea, e.ea);
					chk("next_pc", next_pc, e.npc);
					chk("operand_valid", operand_valid, e.opv);
					if (e.opv) chk("operand", operand, e.opd);
					if (e.mode inside {M_REL_D, M_REL_I}) chk("target", branch_target, e.tgt);
					if (e.mode inside {M_REL_D, M_REL_I}) chk("rel_offset", 16'(rel_offset), 16'(e.rel));
				end
			end
		end
	end

	task automatic run_all();
		logic [7:0] ops [8];
		ops = '{8'h98, 8'h99, 8'h9a, 8'h9b, 8'h80, 8'h83, 8'h8e, 8'h8f};
		rnd();
		issue({8'hf6, 24'h0}, mk(M_IDX0, G_LOAD, 3'h1, {8'h00, x}, 8'h00, 4'h4));
		rnd();
		x = 8'hff;
		b1 = 8'hff;
		issue({8'he6, b1, 16'h0}, mk(M_IDX_S, G_LOAD, 3'h2, 16'h01fe, 8'h00, 4'h4));
		rnd();
		issue({8'he6, b1, 16'h0}, mk(M_IDX_S, G_LOAD, 3'h2, 16'(x) + 16'(b1), 8'h00, 4'h4));
		rnd();
		issue({8'hd6, b1, b2, 8'h0}, mk(M_IDX_L, G_LOAD, 3'h3, {b1, b2} + 16'(x), 8'h00, 4'h4));
		$display("test indexed done");
		rnd();
		issue({8'h92, 8'hc6, b1, 8'h0}, mk(M_IND_L, G_LOAD, 3'h3, ptrw(b1), 8'h00, 4'h4));
		rnd();
		issue({8'h92, 8'hb6, b1, 8'h0}, mk(M_IND_S, G_LOAD, 3'h3, ptrb(b1), 8'h00, 4'h4));
		rnd();
		issue({8'h92, 8'he6, b1, 8'h0}, mk(M_IIX_S, G_LOAD, 3'h3, ptrb(b1) + 16'(x), 8'h00, 4'h4));
		rnd();
		issue({8'h92, 8'hd6, b1, 8'h0}, mk(M_IIX_L, G_LOAD, 3'h3, ptrw(b1) + 16'(x), 8'h00, 4'h4));
		rnd();
		issue({8'h91, 8'hd6, b1, 8'h0}, mk(M_IIX_L, G_LOAD, 3'h3, ptrw(b1) + 16'(y), 8'h00, 4'hc));
		$display("test indirect done");
		rnd();
		issue({8'h90, 8'hf6, 16'h0}, mk(M_IDX0, G_LOAD, 3'h2, {8'h00, y}, 8'h00, 4'hc));
		rnd();
		issue({8'h90, 8'he6, b1, 8'h0}, mk(M_IDX_S, G_LOAD, 3'h3, 16'(y) + 16'(b1), 8'h00, 4'hc));
		rnd();
		issue({8'h3c, b1, 16'h0}, mk(M_DIR_S, G_INCDEC, 3'h2, {8'h00, b1}, 8'h00, 4'h2));
		$display("test prefix done");
		rnd();
		b1 = 8'h80;
		issue({8'h27, b1, 16'h0}, mk(M_REL_D, G_CONDBR, 3'h2, 16'h0000, b1, 4'h0));
		rnd();
		issue({8'h92, 8'h27, b1, 8'h0}, mk(M_REL_I, G_CONDBR, 3'h3, 16'h0000, mem.dmem[{8'h00, b1}], 4'h0));
		$display("test relative done");
		for (int i = 0; i < 8; i++) begin
			rnd();
			issue({ops[i], 24'h0}, mk(M_INH, i < 4 ? G_FLAG : G_INT, 3'h1, 16'h0000, 8'h00, 4'h0));
		end
		rnd();
		issue({8'h92, 8'h9d, 16'h0}, mk(M_INH, G_NONE, 3'h2, 16'h0000, 8'h00, 4'h1));
		rnd();
		issue({8'h90, 8'h90, 16'h0}, mk(M_INH, G_NONE, 3'h2, 16'h0000, 8'h00, 4'h1));
		rnd();
		issue({8'h91, 8'hb6, b1, 8'h0}, mk(M_INH, G_NONE, 3'h2, 16'h0000, 8'h00, 4'h1));
		$display("test groups and refusals done");
	endtask

	// Hang guard, far beyond the expected several hundred cycles
	initial begin
		repeat (20000) @(posedge mclk);
		miscompares++;
		$display("watchdog expired");
		test_done();
	end

	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem.pmem[i] = 8'($random(seed));
			mem.dmem[i] = 8'($random(seed));
		end
		repeat (8) @(posedge mclk);
		#1;
		rst = 1'b0;
		chk("reset busy", busy, 1'b0);
		chk("reset mode", mode, M_INH);
		chk("reset group", group, G_NONE);
		chk("reset ea", ea, 16'h0000);
		$display("test reset values done");
		run_all();
		ce_rand = 1'b1;
		run_all();
		ce_rand = 1'b0;
		// Reset in mid-instruction must drop every request at once
		repeat (2) @(posedge mclk);
		#1;
		rnd();
		start_pc = pc;
		start = 1'b1;
		@(posedge mclk);
		#1;
		start = 1'b0;
		repeat (3) @(posedge mclk);
		#1;
		rst = 1'b1;
		@(posedge mclk);
		#1;
		chk("midrun busy", busy, 1'b0);
		chk("midrun pm_rd", pm_rd, 1'b0);
		chk("midrun dm_rd", dm_rd, 1'b0);
		rst = 1'b0;
		rnd();
		issue({8'hf6, 24'h0}, mk(M_IDX0, G_LOAD, 3'h1, {8'h00, x}, 8'h00, 4'h4));
		$display("test midrun reset done");
		chk("pending results", 16'(expq.size()), 16'h0000);
		test_done();
	end
endmodule
